// [src/ribfc_pkg.sv]
// shared constants and types for the remote input buffer with flow control
package ribfc_pkg;
    localparam int          RIBFC_DEPTH     = 350;
    localparam int          RIBFC_CNT_W     = 9;
    localparam int          RIBFC_PCT_STOP  = 80;
    localparam int          RIBFC_PCT_GO    = 40;
    localparam logic [8:0]  RIBFC_STOP_LVL  = 9'(RIBFC_DEPTH * RIBFC_PCT_STOP / 100);
    localparam logic [8:0]  RIBFC_GO_LVL    = 9'(RIBFC_DEPTH * RIBFC_PCT_GO / 100);
    localparam logic [8:0]  RIBFC_LAST_IDX  = 9'(RIBFC_DEPTH - 1);
    localparam logic [7:0]  RIBFC_XOFF_CHR  = 8'h13;
    localparam logic [7:0]  RIBFC_XON_CHR   = 8'h11;
    localparam logic [8:0]  RIBFC_RST_CNT   = 9'h000;
    localparam logic [7:0]  RIBFC_EOI_DATA  = 8'h00;

    // one store entry: data byte or end-or-identify marker
    typedef struct packed {
        logic       eoi_mark;
        logic [7:0] data;
    } ribfc_entry_t;

    typedef enum logic [1:0] {
        RIBFC_IDLE = 2'b00,
        RIBFC_MARK = 2'b01
    } ribfc_wr_state_t;
endpackage

// [src/ribfc_top.sv]
// remote input buffer: command byte store with bus stall and serial pacing
//////////////////////////////////////////////////////////////////////////////
// Function
// - store up to 350 received bytes, parser drains in arrival order.
// - byte with end-or-identify terminator adds a separate marker entry.
// - hold not-ready on the parallel bus while the store is full.
// - one slot freed lets exactly one further byte through.
// - empty store at reset and on device clear or selected device clear.
// - send stop character when occupancy reaches 80 percent.
// - after stop, send resume character once occupancy drops below 40 percent.
// - hardware mode drops and raises request-to-send at the same levels.
module ribfc_top
    import ribfc_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic                   rx_valid,
    input  wire logic [7:0]             rx_data,
    input  wire logic                   rx_eoi,
    output logic                        rx_ready,
    output logic                        bus_nrfd,
    input  wire logic                   dev_clear,
    input  wire logic                   hw_flow_sel,
    output ribfc_pkg::ribfc_entry_t     cmd_entry,
    output logic                        cmd_valid,
    input  wire logic                   cmd_ready,
    output logic                        tx_ctl_valid,
    output logic [7:0]                  tx_ctl_char,
    input  wire logic                   tx_ctl_ready,
    output logic                        host_rts,
    output logic [8:0]                  fill_level
);
    import ribfc_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // storage
    ribfc_entry_t       mem [RIBFC_DEPTH];
    logic [8:0]         wr_ptr_reg;
    logic [8:0]         wr_ptr_next;
    logic [8:0]         rd_ptr_reg;
    logic [8:0]         rd_ptr_next;
    logic [8:0]         count_reg;
    logic [8:0]         count_next;
    ribfc_wr_state_t    wst_reg;
    ribfc_wr_state_t    wst_next;
    logic               stopped_reg;
    logic               stopped_next;
    logic               tx_pend_reg;
    logic               tx_pend_next;
    logic [7:0]         tx_chr_reg;
    logic [7:0]         tx_chr_next;
    logic               push;
    logic               pop;
    ribfc_entry_t       wr_entry;
    logic               full;
    logic               empty;
    logic               above_stop;
    logic               below_go;

    // circular pointer step over the 350 slots
    function automatic logic [8:0] ptr_inc(input logic [8:0] p);
        if (p == RIBFC_LAST_IDX) begin
            return RIBFC_RST_CNT;
        end
        return 9'(p + 9'h001);
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // handshake and status outputs
    always_comb begin
        full         = (count_reg == 9'(RIBFC_DEPTH));
        empty        = (count_reg == RIBFC_RST_CNT);
        // marker pending blocks new bytes so the marker follows its byte
        rx_ready     = !full && (wst_reg == RIBFC_IDLE) && !dev_clear;
        bus_nrfd     = !rx_ready;
        cmd_valid    = !empty;
        cmd_entry    = mem[rd_ptr_reg];
        pop          = cmd_valid && cmd_ready && !dev_clear;
        fill_level   = count_reg;
        tx_ctl_valid = tx_pend_reg;
        tx_ctl_char  = tx_chr_reg;
        // level follows the stop state in both modes
        host_rts     = !stopped_reg;
    end

    //////////////////////////////////////////////////////////////////////////
    // fixed-count thresholds: stop at or above, resume strictly below
    always_comb begin
        above_stop = (count_reg >= RIBFC_STOP_LVL);
        below_go   = (count_reg < RIBFC_GO_LVL);
    end

    //////////////////////////////////////////////////////////////////////////
    // write side: data byte, then optional marker
    always_comb begin
        wst_next = wst_reg;
        push     = 1'b0;
        wr_entry = '{eoi_mark: 1'b0, data: rx_data};
        if (dev_clear) begin
            wst_next = RIBFC_IDLE;
        end else if (wst_reg == RIBFC_MARK) begin
            if (!full) begin
                push     = 1'b1;
                wr_entry = '{eoi_mark: 1'b1, data: RIBFC_EOI_DATA};
                wst_next = RIBFC_IDLE;
            end
        end else if (rx_valid && rx_ready) begin
            push = 1'b1;
            if (rx_eoi) begin
                wst_next = RIBFC_MARK;
            end
        end
    end

    always_comb begin
        wr_ptr_next = push ? ptr_inc(wr_ptr_reg) : wr_ptr_reg;
        rd_ptr_next = pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
        count_next  = 9'(count_reg + {8'h00, push} - {8'h00, pop});
        if (dev_clear) begin
            wr_ptr_next = RIBFC_RST_CNT;
            rd_ptr_next = RIBFC_RST_CNT;
            count_next  = RIBFC_RST_CNT;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_reg] <= wr_entry;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= RIBFC_RST_CNT;
            rd_ptr_reg <= RIBFC_RST_CNT;
            count_reg  <= RIBFC_RST_CNT;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // write-side state register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wst_reg <= RIBFC_IDLE;
        end else begin
            wst_reg <= wst_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // serial pacing with hysteresis
    // a newer character overwrites one the transmitter has not yet taken
    always_comb begin
        stopped_next = stopped_reg;
        tx_pend_next = tx_pend_reg && !tx_ctl_ready;
        tx_chr_next  = tx_chr_reg;
        if (!stopped_reg && above_stop) begin
            stopped_next = 1'b1;
            if (!hw_flow_sel) begin
                tx_pend_next = 1'b1;
                tx_chr_next  = RIBFC_XOFF_CHR;
            end
        end else if (stopped_reg && below_go) begin
            stopped_next = 1'b0;
            if (!hw_flow_sel) begin
                tx_pend_next = 1'b1;
                tx_chr_next  = RIBFC_XON_CHR;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stopped_reg <= 1'b0;
            tx_pend_reg <= 1'b0;
            tx_chr_reg  <= RIBFC_XON_CHR;
        end else begin
            stopped_reg <= stopped_next;
            tx_pend_reg <= tx_pend_next;
            tx_chr_reg  <= tx_chr_next;
        end
    end
endmodule

// [dv/ribfc_monitor.sv]
// checker on the input buffer ports
module ribfc_monitor import ribfc_pkg::*; (
    input wire logic clk_sys, rst, rx_valid, rx_eoi, rx_ready, bus_nrfd, dev_clear, hw_flow_sel,
    input wire logic cmd_valid, cmd_ready, host_rts, tx_ctl_valid,
    input wire logic [7:0] tx_ctl_char,
    input wire logic [8:0] fill_level);
    timeunit 1ns / 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire push = rx_valid && rx_ready && !dev_clear;
    AST_NRFD: assert property (bus_nrfd == !rx_ready) else $error("nrfd");
    AST_FULL: assert property (fill_level == 9'h15E |-> bus_nrfd) else $error("full");
    AST_PUSH: assert property (push && !rx_eoi && !cmd_ready
        |=> fill_level == $past(fill_level) + 9'h001) else $error("push");
    AST_MARK: assert property (push && rx_eoi |=> !rx_ready) else $error("mark");
    AST_CLR: assert property (dev_clear |=> fill_level == 9'h000) else $error("clear");
    AST_STOP: assert property (fill_level >= RIBFC_STOP_LVL && host_rts |=> !host_rts)
        else $error("stop");
    AST_GO: assert property (fill_level < RIBFC_GO_LVL && !host_rts |=> host_rts)
        else $error("go");
    AST_XOFF: assert property ($fell(host_rts) && !hw_flow_sel
        |-> tx_ctl_valid && tx_ctl_char == RIBFC_XOFF_CHR) else $error("xoff");
    cover property (fill_level == 9'h15E);
    cover property ($rose(host_rts) && !hw_flow_sel);
    cover property (dev_clear && cmd_valid);
endmodule
bind ribfc_top ribfc_monitor mon (.*);

// [dv/ribfc_host.sv]
// far side: bus controller or serial host sending numbered bytes
module ribfc_host import ribfc_pkg::*; (
    input wire logic        clk_sys, rst, go, obey, eoi_on, hw_flow_sel, rx_ready,
    input wire logic        tx_ctl_valid, host_rts,
    input wire logic [7:0]  tx_ctl_char,
    output logic            rx_valid, rx_eoi, tx_ctl_ready,
    output logic [7:0]      rx_data);
    timeunit 1ns / 1ps;
    logic       paused_reg;
    logic [7:0] seq_reg;
    wire halt = obey && (hw_flow_sel ? !host_rts : paused_reg);
    assign rx_data = rx_valid ? seq_reg : ~seq_reg;
    assign rx_eoi = rx_valid && eoi_on;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {paused_reg, tx_ctl_ready, rx_valid, seq_reg} <= '0;
        end else begin
            tx_ctl_ready <= !tx_ctl_ready;
            if (tx_ctl_valid && tx_ctl_ready) paused_reg <= tx_ctl_char == RIBFC_XOFF_CHR;
            if (rx_valid && rx_ready) seq_reg <= seq_reg + 8'h01;
            if (!rx_valid || rx_ready) rx_valid <= go && !halt;
        end
    end
endmodule

// [dv/remote_input_buffer_flow_control_test.sv]
// bench: marker, full stall, character pacing, clear
module remote_input_buffer_flow_control_test;
    timeunit 1ns / 1ps;
    import ribfc_pkg::*;
    logic clk_sys = 0, rst = 1, dev_clear = 0, hw_flow_sel = 1, cmd_ready = 0, go = 0, obey = 0;
    logic eoi_on = 0, rx_valid, rx_eoi, rx_ready, bus_nrfd, cmd_valid, tx_ctl_valid, tx_ctl_ready;
    logic host_rts;
    logic [7:0] rx_data, tx_ctl_char, exp_byte = 8'h00;
    logic [8:0] fill_level;
    ribfc_entry_t cmd_entry;
    int err_count = 0, n_compared = 0, k;
    always #2.5 clk_sys = ~clk_sys;
    ribfc_top uut (.*);
    ribfc_host host (.*);
    task automatic check(input logic [9:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("%0d compared, %0d errors", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic drain();
        @(posedge clk_sys) cmd_ready <= 1;
        @(negedge clk_sys);
        for (k = 0; k < 900 && cmd_valid; k++) begin
            check(10'(cmd_entry.data), 10'(exp_byte));
            exp_byte++;
            @(negedge clk_sys);
        end
        if (k >= 900) begin
            err_count++;
            end_of_test();
        end
        @(posedge clk_sys) cmd_ready <= 0;
    endtask
    task automatic t_marker();
        @(posedge clk_sys) {go, eoi_on} <= 2'b11;
        @(posedge clk_sys) go <= 0;
        repeat (4) @(negedge clk_sys);
        check(10'(fill_level), 10'h002);
        check(10'(cmd_entry), 10'h000);
        @(posedge clk_sys) cmd_ready <= 1;
        @(posedge clk_sys);
        @(negedge clk_sys) check(10'(cmd_entry), 10'({1'b1, RIBFC_EOI_DATA}));
        @(posedge clk_sys) {cmd_ready, eoi_on} <= 2'b00;
        exp_byte = 8'h01;
        $display("marker done");
    endtask
    task automatic t_full();
        @(posedge clk_sys) go <= 1;
        repeat (400) @(negedge clk_sys);
        check(10'(fill_level), 10'h15E);
        check(10'({bus_nrfd, host_rts}), 10'h002);
        check(10'(cmd_entry.data), 10'(exp_byte));
        exp_byte++;
        @(posedge clk_sys) cmd_ready <= 1;
        @(posedge clk_sys) cmd_ready <= 0;
        @(negedge clk_sys) check(10'(rx_ready), 10'h001);
        repeat (3) @(negedge clk_sys);
        check(10'({bus_nrfd, fill_level}), 10'h35E);
        @(posedge clk_sys) go <= 0;
        drain();
        check(10'(host_rts), 10'h001);
        $display("full done");
    endtask
    task automatic t_chars();
        @(posedge clk_sys) {hw_flow_sel, obey, go} <= 3'b011;
        repeat (400) @(negedge clk_sys);
        check(10'(tx_ctl_char), 10'(RIBFC_XOFF_CHR));
        check(10'(fill_level >= RIBFC_STOP_LVL && fill_level < 9'h15E), 10'h001);
        @(posedge clk_sys) go <= 0;
        drain();
        check(10'(tx_ctl_char), 10'(RIBFC_XON_CHR));
        check(10'(tx_ctl_valid), 10'h000);
        $display("chars done");
    endtask
    task automatic t_clear();
        @(posedge clk_sys) go <= 1;
        repeat (20) @(posedge clk_sys);
        go <= 0;
        repeat (3) @(posedge clk_sys);
        dev_clear <= 1;
        @(posedge clk_sys) dev_clear <= 0;
        @(negedge clk_sys) check(10'({cmd_valid, fill_level}), 10'h000);
        $display("clear done");
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 0;
        t_marker();
        t_full();
        t_chars();
        t_clear();
        end_of_test();
    end
endmodule
